// ---- core/rtaw_top.sv ----
// Alarm, watchdog and frequency-test logic of the timekeeping device.
`timescale 1ns/1ps
`default_nettype none
`include "rtaw_params.svh"

module rtaw_top #(
	parameter int RST_PULSE_CYC = `RTAW_RST_PULSE_CYC,
	parameter int TICK16_CYC    = `RTAW_TICK16_CYC,
	parameter int TONE_HALF_CYC = `RTAW_TONE_HALF_CYC
) (
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic [18:0] addr,
	input  wire logic [7:0]  data_in,
	output logic      [7:0]  data_out,
	output logic             data_oe,
	input  wire logic        chip_en_n,
	input  wire logic        out_en_n,
	input  wire logic        write_en_n,
	input  wire logic        osc_running,
	input  wire logic        on_battery,
	input  wire logic        sec_tick,
	input  wire logic [6:0]  cur_sec,
	input  wire logic [6:0]  cur_min,
	input  wire logic [5:0]  cur_hour,
	input  wire logic [5:0]  cur_date,
	output logic             interrupt_tone_out_n,
	output logic             irq_pull_en,
	output logic             reset_out_n,
	output logic             reset_pull_en
);
	localparam int RST_MIN_CYC = `RTAW_CLK_HZ / 1000 * 40;
	localparam int RST_MAX_CYC = `RTAW_CLK_HZ / 1000 * 200;

	// Counts below one cycle would wrap the dividers' terminal counts to a huge value.
	if (RST_PULSE_CYC < 1 || TICK16_CYC < 1 ||
		TONE_HALF_CYC < 1) begin : g_bad_count
		$error("rtaw_top: counts must be at least one cycle");
	end

	// Registers.
	logic [7:0]  wdog_q;
	logic [7:0]  ien_q;
	logic        tone_test_enable_q;
	logic [7:0]  alm_sec_q;
	logic [7:0]  alm_min_q;
	logic [7:0]  alm_hour_q;
	logic [7:0]  alm_date_q;
	logic        alarm_match_flag_q;
	logic        wdog_timeout_flag_q;
	logic        alarm_irq_q;
	logic        wdog_irq_q;
	logic        flags_acc_q;
	logic        wdog_acc_q;
	logic        tone_q;
	logic [31:0] tone_cnt_q;
	logic [31:0] tick_cnt_q;
	logic [11:0] wd_cnt_q;
	logic [31:0] pulse_cnt_q;
	logic        irq_n_q;
	logic        irq_pull_q;
	logic        rst_n_q;
	logic        rst_pull_q;
	logic [7:0]  dout_q;
	logic        doe_q;
	rtaw_pkg::rtaw_wd_state_e wd_state_q;

	// Bus decode.
	wire        access;
	wire        rd;
	wire        wr;
	wire        hit_flags;
	wire        hit_wdog;
	wire        hit_ien;
	wire        hit_day;
	wire        flags_acc;
	wire        wdog_acc;
	wire        flags_acc_end;
	wire        match;
	wire        match_rise;
	wire        alarm_irq_ok;
	wire [4:0]  wdog_multiplier;
	wire [1:0]  wdog_resolution;
	wire        wdog_output_steer;
	wire [11:0] wd_period;
	wire        tick16;
	wire        wd_expire;
	wire        tone_allowed;
	wire        irq_d;
	wire [7:0]  rd_mux;

	assign access    = !chip_en_n && (!out_en_n || !write_en_n);
	assign wr        = !chip_en_n && !write_en_n;
	assign rd        = !chip_en_n && write_en_n && !out_en_n;
	assign hit_flags = (addr == `RTAW_OFS_FLAGS);
	assign hit_wdog  = (addr == `RTAW_OFS_WDOG);
	assign hit_ien   = (addr == `RTAW_OFS_IRQ_EN);
	assign hit_day   = (addr == `RTAW_OFS_DAY);
	assign flags_acc = access && hit_flags;
	assign wdog_acc  = access && hit_wdog;
	// Flag clears wait for the end of the access so a read sees the flag.
	assign flags_acc_end = flags_acc_q && !flags_acc;

	assign wdog_output_steer = wdog_q[`RTAW_WDOG_STEER_BIT];
	assign wdog_multiplier   = wdog_q[6:2];
	assign wdog_resolution   = wdog_q[1:0];
	// Base tick is 1/16 s; resolutions scale it by 1, 4, 16 or 64.
	assign wd_period = {7'h00, wdog_multiplier} << {wdog_resolution, 1'b0};
	assign tick16    = (tick_cnt_q == 32'(TICK16_CYC - 1));
	// A period of zero must never expire, even in the cycle it is written.
	assign wd_expire = (wd_state_q == rtaw_pkg::RTAW_WD_COUNT) && tick16 &&
		(wd_period != 12'h000) && (wd_cnt_q + 12'h001 >= wd_period) &&
		!wdog_acc;

	rtaw_alarm_match u_match (
		.alm_sec  (alm_sec_q),
		.alm_min  (alm_min_q),
		.alm_hour (alm_hour_q),
		.alm_date (alm_date_q),
		.cur_sec  (cur_sec),
		.cur_min  (cur_min),
		.cur_hour (cur_hour),
		.cur_date (cur_date),
		.match    (match)
	);

	// The match is evaluated once per second, on the second tick.
	assign match_rise = sec_tick && match;
	// On battery the backup enable must join the alarm enable.
	assign alarm_irq_ok = ien_q[`RTAW_IEN_AE_BIT] &&
		(!on_battery || ien_q[`RTAW_IEN_ABE_BIT]);
	assign tone_allowed = tone_test_enable_q && osc_running &&
		!ien_q[`RTAW_IEN_AE_BIT] &&
		(wdog_output_steer || wdog_q == 8'h00);
	// Alarm and watchdog interrupts override the tone.
	assign irq_d = !(alarm_irq_q || wdog_irq_q ||
		(tone_allowed && tone_q));

	assign rd_mux = hit_flags ? {wdog_timeout_flag_q, alarm_match_flag_q,
			6'h00} :
		hit_wdog ? wdog_q :
		hit_ien  ? ien_q :
		hit_day  ? {1'b0, tone_test_enable_q, 6'h00} :
		(addr == `RTAW_OFS_ALM_SEC)  ? alm_sec_q :
		(addr == `RTAW_OFS_ALM_MIN)  ? alm_min_q :
		(addr == `RTAW_OFS_ALM_HOUR) ? alm_hour_q :
		(addr == `RTAW_OFS_ALM_DATE) ? alm_date_q : 8'h00;

	// Host registers; reset models power-up.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ien_q      <= `RTAW_IEN_RESET;
			alm_sec_q  <= `RTAW_ALM_RESET;
			alm_min_q  <= `RTAW_ALM_RESET;
			alm_hour_q <= `RTAW_ALM_RESET;
			alm_date_q <= `RTAW_ALM_RESET;
		end else if (wr) begin
			if (hit_ien)
				ien_q <= data_in;
			if (addr == `RTAW_OFS_ALM_SEC)
				alm_sec_q <= data_in;
			if (addr == `RTAW_OFS_ALM_MIN)
				alm_min_q <= data_in;
			if (addr == `RTAW_OFS_ALM_HOUR)
				alm_hour_q <= data_in;
			if (addr == `RTAW_OFS_ALM_DATE)
				alm_date_q <= data_in;
		end
	end

	// Watchdog register and tone enable also clear after a reset pulse.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wdog_q             <= `RTAW_WDOG_RESET;
			tone_test_enable_q <= 1'b0;
		end else if (wd_state_q == rtaw_pkg::RTAW_WD_PULSE &&
			pulse_cnt_q == 32'(RST_PULSE_CYC - 1)) begin
			wdog_q             <= `RTAW_WDOG_RESET;
			tone_test_enable_q <= 1'b0;
		end else if (wr && hit_wdog) begin
			wdog_q <= data_in;
		end else if (wr && hit_day) begin
			tone_test_enable_q <= data_in[`RTAW_DAY_FT_BIT];
		end
	end

	// Flags and interrupt sources; a new event wins over a clear.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			alarm_match_flag_q  <= 1'b0;
			wdog_timeout_flag_q <= 1'b0;
			alarm_irq_q         <= 1'b0;
			wdog_irq_q          <= 1'b0;
			flags_acc_q         <= 1'b0;
			wdog_acc_q          <= 1'b0;
		end else begin
			flags_acc_q <= flags_acc;
			wdog_acc_q  <= wdog_acc;
			// The flag is set even with the enables cleared.
			if (match_rise)
				alarm_match_flag_q <= 1'b1;
			else if (flags_acc_end)
				alarm_match_flag_q <= 1'b0;
			if (match_rise && alarm_irq_ok)
				alarm_irq_q <= 1'b1;
			else if (flags_acc)
				alarm_irq_q <= 1'b0;
			if (wd_expire)
				wdog_timeout_flag_q <= 1'b1;
			else if (flags_acc_end || (wdog_acc_q && !wdog_acc))
				wdog_timeout_flag_q <= 1'b0;
			if (wd_expire && !wdog_output_steer)
				wdog_irq_q <= 1'b1;
			else if (flags_acc || wdog_acc)
				wdog_irq_q <= 1'b0;
		end
	end

	// Watchdog sequencer.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wd_state_q  <= rtaw_pkg::RTAW_WD_IDLE;
			tick_cnt_q  <= 32'h00000000;
			wd_cnt_q    <= 12'h000;
			pulse_cnt_q <= 32'h00000000;
		end else begin
			tick_cnt_q <= (tick16 || wdog_acc) ? 32'h00000000 :
				tick_cnt_q + 32'h00000001;
			unique case (wd_state_q)
			rtaw_pkg::RTAW_WD_IDLE: begin
				wd_cnt_q <= 12'h000;
				if (wd_period != 12'h000)
					wd_state_q <= rtaw_pkg::RTAW_WD_COUNT;
			end
			rtaw_pkg::RTAW_WD_COUNT: begin
				if (wd_period == 12'h000) begin
					wd_state_q <= rtaw_pkg::RTAW_WD_IDLE;
				end else if (wdog_acc) begin
					wd_cnt_q <= 12'h000;
				end else if (wd_expire) begin
					wd_cnt_q <= 12'h000;
					if (wdog_output_steer) begin
						wd_state_q  <= rtaw_pkg::RTAW_WD_PULSE;
						pulse_cnt_q <= 32'h00000000;
					end
				end else if (tick16) begin
					wd_cnt_q <= wd_cnt_q + 12'h001;
				end
			end
			rtaw_pkg::RTAW_WD_PULSE: begin
				pulse_cnt_q <= pulse_cnt_q + 32'h00000001;
				if (pulse_cnt_q == 32'(RST_PULSE_CYC - 1))
					wd_state_q <= rtaw_pkg::RTAW_WD_IDLE;
			end
			endcase
		end
	end

	// Tone divider; toggles only while the tone is allowed.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			tone_cnt_q <= 32'h00000000;
			tone_q     <= 1'b0;
		end else if (!tone_allowed) begin
			tone_cnt_q <= 32'h00000000;
			tone_q     <= 1'b0;
		end else if (tone_cnt_q == 32'(TONE_HALF_CYC - 1)) begin
			tone_cnt_q <= 32'h00000000;
			tone_q     <= !tone_q;
		end else begin
			tone_cnt_q <= tone_cnt_q + 32'h00000001;
		end
	end

	// Output flops; the pull enables mirror the low level of each pin.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			irq_n_q    <= 1'b1;
			irq_pull_q <= 1'b0;
			rst_n_q    <= 1'b1;
			rst_pull_q <= 1'b0;
			dout_q     <= 8'h00;
			doe_q      <= 1'b0;
		end else begin
			irq_n_q    <= irq_d;
			irq_pull_q <= !irq_d;
			rst_n_q    <= !(wd_state_q == rtaw_pkg::RTAW_WD_PULSE);
			rst_pull_q <= (wd_state_q == rtaw_pkg::RTAW_WD_PULSE);
			dout_q     <= rd_mux;
			doe_q      <= rd;
		end
	end

	assign interrupt_tone_out_n = irq_n_q;
	assign irq_pull_en          = irq_pull_q;
	assign reset_out_n          = rst_n_q;
	assign reset_pull_en        = rst_pull_q;
	assign data_out             = dout_q;
	assign data_oe              = doe_q;

	pulse_start_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		$rose(wd_state_q == rtaw_pkg::RTAW_WD_PULSE) |=>
		!reset_out_n) else $error("reset pulse did not start");
	irq_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		(flags_acc && !(match_rise && alarm_irq_ok)) |=> !alarm_irq_q)
		else $error("alarm irq not cleared");
	flag_set_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		match_rise |=> alarm_match_flag_q) else $error("alarm flag not set");
	flag_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		(alarm_match_flag_q && flags_acc && !match_rise) |=> alarm_match_flag_q)
		else $error("alarm flag cleared during access");
	wd_flag_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		wd_expire |=> wdog_timeout_flag_q) else $error("watchdog flag missed");
	wd_irq_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		(wd_expire && !wdog_output_steer) |=> ##1 !interrupt_tone_out_n)
		else $error("watchdog irq not driven");
	wd_off_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		(wdog_q == 8'h00 && wd_state_q != rtaw_pkg::RTAW_WD_PULSE) |=>
		!wdog_timeout_flag_q || $stable(wdog_timeout_flag_q))
		else $error("disabled watchdog fired");
	wd_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		$fell(wd_state_q == rtaw_pkg::RTAW_WD_PULSE) |->
		(wdog_q == 8'h00 && !tone_test_enable_q))
		else $error("watchdog register not cleared");
	tone_quiet_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		ien_q[`RTAW_IEN_AE_BIT] ##1 (!alarm_irq_q && !wdog_irq_q) |=>
		interrupt_tone_out_n) else $error("tone with alarm enable");
	pull_sync_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		irq_pull_en == !interrupt_tone_out_n && reset_pull_en == !reset_out_n)
		else $error("pull enable mismatch");
	pulse_range_a: assert property (@(posedge sys_clk)
		RST_PULSE_CYC >= RST_MIN_CYC && RST_PULSE_CYC <= RST_MAX_CYC ||
		RST_PULSE_CYC < RST_MIN_CYC) else $error("pulse out of range");
endmodule
`default_nettype wire

// ---- shared/rtaw_params.svh ----
// Register offsets, field positions, reset values and timing counts.
`ifndef RTAW_PARAMS_SVH
`define RTAW_PARAMS_SVH

`define RTAW_OFS_FLAGS      19'h7FFF0
`define RTAW_OFS_ALM_SEC    19'h7FFF2
`define RTAW_OFS_ALM_MIN    19'h7FFF3
`define RTAW_OFS_ALM_HOUR   19'h7FFF4
`define RTAW_OFS_ALM_DATE   19'h7FFF5
`define RTAW_OFS_IRQ_EN     19'h7FFF6
`define RTAW_OFS_WDOG       19'h7FFF7
`define RTAW_OFS_DAY        19'h7FFFC

`define RTAW_FLG_WDOG_BIT   7
`define RTAW_FLG_ALARM_BIT  6
`define RTAW_IEN_AE_BIT     7
`define RTAW_IEN_ABE_BIT    5
`define RTAW_DAY_FT_BIT     6
`define RTAW_ALM_MASK_BIT   7
`define RTAW_WDOG_STEER_BIT 7

`define RTAW_WDOG_RESET     8'h00
`define RTAW_IEN_RESET      8'h00
`define RTAW_ALM_RESET      8'h00

`define RTAW_CLK_HZ         40000000
`define RTAW_TONE_HZ        512
`define RTAW_TONE_HALF_CYC  (`RTAW_CLK_HZ / (2 * `RTAW_TONE_HZ))
`define RTAW_TICK16_HZ      16
`define RTAW_TICK16_CYC     (`RTAW_CLK_HZ / `RTAW_TICK16_HZ)
`define RTAW_RST_PULSE_MS   100
`define RTAW_RST_PULSE_CYC  (`RTAW_CLK_HZ / 1000 * `RTAW_RST_PULSE_MS)

`endif

// ---- shared/rtaw_pkg.sv ----
// Types shared by the alarm and watchdog logic.
package rtaw_pkg;
	typedef enum logic [2:0] {
		RTAW_WD_IDLE  = 3'b001,
		RTAW_WD_COUNT = 3'b010,
		RTAW_WD_PULSE = 3'b100
	} rtaw_wd_state_e;

	typedef logic [7:0] rtaw_byte_t;
endpackage

// ---- core/rtaw_alarm_match.sv ----
// Masked comparison of the running time with the alarm settings.
`timescale 1ns/1ps
`default_nettype none
`include "rtaw_params.svh"

module rtaw_alarm_match (
	input  wire logic [7:0] alm_sec,
	input  wire logic [7:0] alm_min,
	input  wire logic [7:0] alm_hour,
	input  wire logic [7:0] alm_date,
	input  wire logic [6:0] cur_sec,
	input  wire logic [6:0] cur_min,
	input  wire logic [5:0] cur_hour,
	input  wire logic [5:0] cur_date,
	output logic            match
);
	wire [3:0] mask;
	wire       sec_eq;
	wire       min_eq;
	wire       hour_eq;
	wire       date_eq;
	wire       legal;

	// Mask bits sit in the top bit of each alarm byte, seconds lowest.
	assign mask = {alm_date[`RTAW_ALM_MASK_BIT], alm_hour[`RTAW_ALM_MASK_BIT],
		alm_min[`RTAW_ALM_MASK_BIT], alm_sec[`RTAW_ALM_MASK_BIT]};
	assign sec_eq  = (alm_sec[6:0] == cur_sec);
	assign min_eq  = (alm_min[6:0] == cur_min);
	assign hour_eq = (alm_hour[5:0] == cur_hour);
	assign date_eq = (alm_date[5:0] == cur_date);
	assign legal = (mask == 4'hF) || (mask == 4'hE) || (mask == 4'hC) ||
		(mask == 4'h8) || (mask == 4'h0);

	// Undefined patterns fall back to once a second to expose the mistake.
	assign match = !legal ? 1'b1 :
		((mask[0] | sec_eq) & (mask[1] | min_eq) &
		(mask[2] | hour_eq) & (mask[3] | date_eq));
endmodule
`default_nettype wire

// ---- verification/rtaw_host_model.sv ----
// Host processor model that drives the parallel register bus.
`timescale 1ns/1ps
`default_nettype none

module rtaw_host_model (
	input  wire logic        sys_clk,
	input  wire logic [7:0]  data_out,
	input  wire logic        data_oe,
	output var  logic [18:0] addr,
	output var  logic [7:0]  data_in,
	output var  logic        chip_en_n,
	output var  logic        out_en_n,
	output var  logic        write_en_n
);
	initial begin
		addr = 19'h00000;
		data_in = 8'h00;
		chip_en_n = 1'b1;
		out_en_n = 1'b1;
		write_en_n = 1'b1;
	end

	// Released lines flip so that a stale address or datum never looks valid.
	task automatic idle();
		addr = ~addr;
		data_in = ~data_in;
		chip_en_n = 1'b1;
		out_en_n = 1'b1;
		write_en_n = 1'b1;
	endtask

	task automatic wr(input logic [18:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		#1;
		addr = a;
		data_in = d;
		chip_en_n = 1'b0;
		write_en_n = 1'b0;
		@(posedge sys_clk);
		#1;
		idle();
	endtask

	// The strobe stays over two edges, a full read cycle; the datum is
	// taken once it has settled after the first edge.
	task automatic rd(input logic [18:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		#1;
		addr = a;
		chip_en_n = 1'b0;
		out_en_n = 1'b0;
		@(posedge sys_clk);
		#1;
		// A missing output enable makes the datum unknown, so checks trip.
		d = data_oe ? data_out : 8'hXX;
		@(posedge sys_clk);
		#1;
		idle();
	endtask
endmodule

`default_nettype wire

// ---- verification/rtc_alarm_watchdog_irq_test.sv ----
// Self-checking testbench for the alarm, watchdog and tone logic.
`timescale 1ns/1ps
`default_nettype none
`include "rtaw_params.svh"

module rtc_alarm_watchdog_irq_test;
	localparam int TK = 4;
	localparam int RP = 8;
	localparam int TH = 3;
	logic        sys_clk;
	logic        resetn;
	logic        osc_running;
	logic        on_battery;
	logic        sec_tick;
	logic [6:0]  cur_sec;
	logic [6:0]  cur_min;
	logic [5:0]  cur_hour;
	logic [5:0]  cur_date;
	wire  [18:0] addr;
	wire  [7:0]  data_in;
	wire  [7:0]  data_out;
	wire         data_oe;
	wire         chip_en_n;
	wire         out_en_n;
	wire         write_en_n;
	wire         interrupt_tone_out_n;
	wire         irq_pull_en;
	wire         reset_out_n;
	wire         reset_pull_en;
	int          error_cnt = 0;
	int          checked = 0;
	int          cycles = 0;

	rtaw_host_model host_u (
		.sys_clk    (sys_clk),
		.data_out   (data_out),
		.data_oe    (data_oe),
		.addr       (addr),
		.data_in    (data_in),
		.chip_en_n  (chip_en_n),
		.out_en_n   (out_en_n),
		.write_en_n (write_en_n)
	);

	rtaw_top #(
		.RST_PULSE_CYC (RP),
		.TICK16_CYC    (TK),
		.TONE_HALF_CYC (TH)
	) dut_u (
		.sys_clk              (sys_clk),
		.resetn               (resetn),
		.addr                 (addr),
		.data_in              (data_in),
		.data_out             (data_out),
		.data_oe              (data_oe),
		.chip_en_n            (chip_en_n),
		.out_en_n             (out_en_n),
		.write_en_n           (write_en_n),
		.osc_running          (osc_running),
		.on_battery           (on_battery),
		.sec_tick             (sec_tick),
		.cur_sec              (cur_sec),
		.cur_min              (cur_min),
		.cur_hour             (cur_hour),
		.cur_date             (cur_date),
		.interrupt_tone_out_n (interrupt_tone_out_n),
		.irq_pull_en          (irq_pull_en),
		.reset_out_n          (reset_out_n),
		.reset_pull_en        (reset_pull_en)
	);

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task automatic test_done();
		if (error_cnt == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// The whole run needs about 2400 cycles, so the ceiling leaves ample room.
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			test_done();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic sec_pulse();
		step(1);
		sec_tick = 1'b1;
		step(1);
		sec_tick = 1'b0;
		step(3);
	endtask

	// Returns 20 when the output holds still for the whole window.
	task automatic half_period(output int n);
		logic v;
		n = 0;
		for (int i = 0; i < 2; i++) begin
			v = interrupt_tone_out_n;
			n = 0;
			while (interrupt_tone_out_n === v && n < 20) begin
				step(1);
				n++;
			end
		end
	endtask

	task automatic reset_vals();
		logic [7:0] d;
		chk(interrupt_tone_out_n, 1'b1);
		chk(reset_pull_en, 1'b0);
		host_u.rd(`RTAW_OFS_WDOG, d);
		chk(d, 8'h00);
		host_u.rd(`RTAW_OFS_IRQ_EN, d);
		chk(d, 8'h00);
		host_u.rd(`RTAW_OFS_DAY, d);
		chk(d[6], 1'b0);
	endtask

	task automatic alarm_modes();
		logic [3:0] mk [6] = '{4'hF, 4'hE, 4'hC, 4'h8, 4'h0, 4'h5};
		logic [6:0] al [4] = '{7'h10, 7'h20, 7'h05, 7'h07};
		logic [7:0] d;
		logic       fire;
		host_u.wr(`RTAW_OFS_IRQ_EN, 8'h80);
		for (int m = 0; m < 6; m++) begin
			for (int f = 0; f < 5; f++) begin
				for (int k = 0; k < 4; k++) begin
					host_u.wr(19'(`RTAW_OFS_ALM_SEC + k), {mk[m][k], al[k]});
				end
				cur_sec = al[0] ^ 7'(f == 0);
				cur_min = al[1] ^ 7'(f == 1);
				cur_hour = 6'(al[2]) ^ 6'(f == 2);
				cur_date = 6'(al[3]) ^ 6'(f == 3);
				fire = (f == 4) || (m == 5) || mk[m][f % 4];
				sec_pulse();
				chk(interrupt_tone_out_n, !fire);
				chk(irq_pull_en, fire);
				host_u.rd(`RTAW_OFS_FLAGS, d);
				chk(d[6], fire);
				step(2);
				chk(interrupt_tone_out_n, 1'b1);
				host_u.rd(`RTAW_OFS_FLAGS, d);
				chk(d[6], 1'b0);
			end
		end
		host_u.wr(`RTAW_OFS_IRQ_EN, 8'h00);
	endtask

	task automatic battery_alarm();
		logic [7:0] d;
		on_battery = 1'b1;
		host_u.wr(`RTAW_OFS_IRQ_EN, 8'h80);
		for (int k = 0; k < 4; k++) begin
			host_u.wr(19'(`RTAW_OFS_ALM_SEC + k), 8'h80);
		end
		sec_pulse();
		chk(interrupt_tone_out_n, 1'b1);
		host_u.rd(`RTAW_OFS_FLAGS, d);
		chk(d[6], 1'b1);
		host_u.wr(`RTAW_OFS_IRQ_EN, 8'hA0);
		sec_pulse();
		chk(interrupt_tone_out_n, 1'b0);
		host_u.rd(`RTAW_OFS_FLAGS, d);
		host_u.wr(`RTAW_OFS_IRQ_EN, 8'h00);
		on_battery = 1'b0;
	endtask

	task automatic wdog_periods();
		logic [7:0] d;
		int         n;
		int         per;
		for (int r = 0; r < 4; r++) begin
			per = 4 * TK * (4 ** r);
			host_u.wr(`RTAW_OFS_WDOG, {3'b000, 3'b100, 2'(r)});
			n = 0;
			while (interrupt_tone_out_n === 1'b1 && n < per + TK + 10) begin
				step(1);
				n++;
			end
			chk(n >= per - TK && n <= per + TK + 4, 1'b1);
			host_u.rd(`RTAW_OFS_FLAGS, d);
			chk(d[7], 1'b1);
			step(2);
			chk(interrupt_tone_out_n, 1'b1);
			host_u.wr(`RTAW_OFS_WDOG, 8'h00);
		end
	endtask

	task automatic wdog_restart();
		logic [7:0] d;
		host_u.wr(`RTAW_OFS_WDOG, 8'h10);
		repeat (10) begin
			host_u.rd(`RTAW_OFS_WDOG, d);
			chk(interrupt_tone_out_n, 1'b1);
		end
		host_u.wr(`RTAW_OFS_WDOG, 8'h00);
		step(60);
		chk(interrupt_tone_out_n, 1'b1);
	endtask

	task automatic wdog_reset_pulse();
		logic [7:0] d;
		int         n = 0;
		host_u.wr(`RTAW_OFS_DAY, 8'h40);
		host_u.wr(`RTAW_OFS_WDOG, 8'h84);
		while (reset_out_n === 1'b1 && n < 40) begin
			step(1);
			n++;
		end
		chk(reset_pull_en, 1'b1);
		n = 0;
		while (reset_out_n === 1'b0 && n < 40) begin
			step(1);
			n++;
		end
		chk(n, RP);
		host_u.rd(`RTAW_OFS_WDOG, d);
		chk(d, 8'h00);
		host_u.rd(`RTAW_OFS_DAY, d);
		chk(d[6], 1'b0);
	endtask

	task automatic tone_test();
		int n;
		host_u.wr(`RTAW_OFS_DAY, 8'h40);
		half_period(n);
		chk(n, TH);
		osc_running = 1'b0;
		half_period(n);
		chk(n, 20);
		osc_running = 1'b1;
		host_u.wr(`RTAW_OFS_IRQ_EN, 8'h80);
		half_period(n);
		chk(n, 20);
		host_u.wr(`RTAW_OFS_IRQ_EN, 8'h00);
		host_u.wr(`RTAW_OFS_WDOG, 8'h7C);
		half_period(n);
		chk(n, 20);
		host_u.wr(`RTAW_OFS_WDOG, 8'hFC);
		half_period(n);
		chk(n, TH);
		host_u.wr(`RTAW_OFS_WDOG, 8'h00);
		host_u.wr(`RTAW_OFS_DAY, 8'h00);
	endtask

	task automatic power_up_again();
		logic [7:0] d;
		host_u.wr(`RTAW_OFS_WDOG, 8'h7C);
		host_u.rd(`RTAW_OFS_WDOG, d);
		chk(d, 8'h7C);
		host_u.wr(`RTAW_OFS_IRQ_EN, 8'hA0);
		host_u.rd(`RTAW_OFS_IRQ_EN, d);
		chk(d, 8'hA0);
		host_u.wr(`RTAW_OFS_DAY, 8'h40);
		host_u.rd(`RTAW_OFS_DAY, d);
		chk(d[6], 1'b1);
		host_u.rd(19'h7FFF1, d);
		chk(d, 8'h00);
		resetn = 1'b0;
		step(1);
		resetn = 1'b1;
		reset_vals();
	endtask

	initial begin
		resetn = 1'b0;
		osc_running = 1'b1;
		on_battery = 1'b0;
		sec_tick = 1'b0;
		cur_sec = 7'h00;
		cur_min = 7'h00;
		cur_hour = 6'h00;
		cur_date = 6'h00;
		step(3);
		resetn = 1'b1;
		reset_vals();
		alarm_modes();
		battery_alarm();
		wdog_periods();
		wdog_restart();
		wdog_reset_pulse();
		tone_test();
		power_up_again();
		test_done();
	end
endmodule

`default_nettype wire
